/* verilog/mlink_defs.svh */
`ifndef MLINK_DEFS_SVH
`define MLINK_DEFS_SVH
// Contract
// - Read command check is inverted sum plus 33h
// - Length byte echoes count, zero reported one
// - Response starts header, control, then length
// - First word sent low byte to high
// - Word k from start address plus k-1
// - Final byte checks all 4N+3 preceding bytes
// - Host sends eight-byte broadcast write frame
// - Broadcast write performed, never answered
// - Every byte travels least significant bit first
// - Host waits 1 ms between broadcasts
// - Broadcast address byte, data LSB first, check
// - Command eight bytes, response 4N+4 bytes
// - First data byte gives count, zero one

// ----------------------------------------
// Frame bytes
// ----------------------------------------
`define ML_HEAD_BYTE    8'h7D
`define ML_CHK_CONST    8'h33
`define ML_CMD_LEN      4'h8
`define ML_OP_BCAST     2'h0
`define ML_OP_WRITE     2'h2
`define ML_OP_READ      2'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define ML_CLK_HZ       25000000
`define ML_BIT_DIV      8'h18
`define ML_BCAST_GAP_US 1000
`define ML_BCAST_GAP_CYC ((`ML_CLK_HZ / 1000000) * `ML_BCAST_GAP_US)
`endif

/* verilog/mlink_pkg.sv */
package mlink_pkg;
  // Receiver and transmitter states, not used by either end
  typedef enum logic [1:0]
  {
    LS_IDLE = 2'b00,
    LS_SHIFT = 2'b01,
    LS_STOP = 2'b10
  } link_state_t;

  // Device frame states
  typedef enum logic [1:0]
  {
    DV_RECV = 2'b00,
    DV_RESP = 2'b01,
    DV_WAIT = 2'b10
  } dev_state_t;
endpackage

/* verilog/mlink_if.sv */
// ----------------------------------------
// Serial link between host and device
// ----------------------------------------
interface mlink_if;
  logic tx_host;   // Host to device line, idle high
  logic tx_dev;    // Device to host line, idle high
  logic tx_dev_oe; // Device drives its line

  modport host (output tx_host, input tx_dev, input tx_dev_oe);
  modport dev (input tx_host, output tx_dev, output tx_dev_oe);
endinterface

/* verilog/mlink_dev.sv */
`include "mlink_defs.svh"
// ----------------------------------------
// Device end: frame decode and response
// ----------------------------------------
module mlink_dev
  import mlink_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  mlink_if.dev             link,
  output logic             reg_wr,       // One-cycle write strobe
  output logic [11:0]      reg_addr,     // Register address of write or read
  output logic [31:0]      reg_wdata,    // Write data
  input  wire logic [31:0] reg_rdata,    // Read data for reg_addr, same cycle
  output logic             frame_bad     // One-cycle pulse on check failure
);
  // ----------------------------------------
  // Bit timing and input synchroniser
  // ----------------------------------------
  logic       rx_s1_r;          // First stage, read only by second
  logic       rx_s2_r;          // Synchronised line
  logic [7:0] div_r;            // Bit period divider
  logic [3:0] rbit_r;           // Receive bit index
  logic [7:0] rsh_r;            // Receive shift register
  logic       rbusy_r;          // Receiving a byte
  logic       rx_done;          // Byte complete pulse
  logic       half_tick;
  logic       full_tick;

  assign half_tick = (div_r == (`ML_BIT_DIV >> 1));
  assign full_tick = (div_r == `ML_BIT_DIV);
  assign rx_done   = rbusy_r && full_tick && (rbit_r == 4'h9);

  // Two flops before any logic sees the line
  always_ff @(posedge clk_sys)
  begin
    rx_s1_r <= reset_n ? link.tx_host : 1'b1;
    rx_s2_r <= reset_n ? rx_s1_r : 1'b1;
  end

  // Start-bit hunt and mid-bit sampling, LSB first
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rbusy_r <= 1'b0;
      div_r   <= 8'h00;
      rbit_r  <= 4'h0;
      rsh_r   <= 8'h00;
    end
    else if (!rbusy_r)
    begin
      div_r   <= 8'h00;
      rbit_r  <= 4'h0;
      rbusy_r <= !rx_s2_r;
    end
    else
    begin
      div_r <= full_tick ? 8'h00 : div_r + 8'h01;
      if (half_tick && rbit_r >= 4'h1 && rbit_r <= 4'h8)
        rsh_r <= {rx_s2_r, rsh_r[7:1]};
      if (full_tick)
        rbit_r <= rbit_r + 4'h1;
      if (rx_done)
        rbusy_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Command frame collection
  // ----------------------------------------
  dev_state_t st_r;
  logic [3:0] cnt_r;            // Bytes of command held
  logic [7:0] sum_r;            // Running sum of command bytes
  logic [7:0] ctl_r;
  logic [7:0] adr_r;
  logic [31:0] dat_r;
  logic [7:0] chk_want;
  logic       chk_ok;
  logic [1:0] op;

  assign chk_want = (~sum_r) + `ML_CHK_CONST;
  assign chk_ok   = (rsh_r == chk_want);
  assign op       = ctl_r[1:0];

  // Response generator
  logic [7:0]  nword_r;         // Words still to send
  logic [1:0]  bsel_r;          // Byte within word
  logic [2:0]  phase_r;         // 0 hdr,1 ctl,2 len,3 data,4 chk
  logic [7:0]  tsum_r;          // Running sum of sent bytes
  logic [31:0] word_r;          // Captured word
  logic [7:0]  tbyte;           // Byte to send next
  logic        tbusy_r;
  logic [9:0]  tsh_r;           // Frame with start and stop
  logic [7:0]  tdiv_r;
  logic [3:0]  tbit_r;
  logic        tload;
  logic [7:0]  len_byte;

  assign len_byte = (dat_r[7:0] == 8'h00) ? 8'h01 : dat_r[7:0];

  // Byte selection per response phase
  assign tbyte = (phase_r == 3'h0) ? `ML_HEAD_BYTE :
                 (phase_r == 3'h1) ? {ctl_r[7:4], 4'h1} :
                 (phase_r == 3'h2) ? len_byte :
                 (phase_r == 3'h3) ? word_r[8*bsel_r +: 8] :
                 ((~tsum_r) + `ML_CHK_CONST);
  assign tload = (st_r == DV_RESP) && !tbusy_r;

  // Frame decode and write strobe
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      st_r      <= DV_RECV;
      cnt_r     <= 4'h0;
      sum_r     <= 8'h00;
      ctl_r     <= 8'h00;
      adr_r     <= 8'h00;
      dat_r     <= 32'h0000_0000;
      reg_wr    <= 1'b0;
      frame_bad <= 1'b0;
      reg_addr  <= 12'h000;
      reg_wdata <= 32'h0000_0000;
      phase_r   <= 3'h0;
      nword_r   <= 8'h00;
      bsel_r    <= 2'h0;
      tsum_r    <= 8'h00;
      word_r    <= 32'h0000_0000;
    end
    else
    begin
      reg_wr    <= 1'b0;
      frame_bad <= 1'b0;
      unique case (st_r)
        DV_RECV:
        begin
          if (rx_done)
          begin
            if (cnt_r == 4'h0 && rsh_r != `ML_HEAD_BYTE)
              cnt_r <= 4'h0;                // Resync on header
            else if (cnt_r == `ML_CMD_LEN - 4'h1)
            begin
              cnt_r <= 4'h0;
              sum_r <= 8'h00;
              if (!chk_ok)
                frame_bad <= 1'b1;
              else if (op == `ML_OP_READ)
              begin
                st_r     <= DV_RESP;
                phase_r  <= 3'h0;
                nword_r  <= len_byte;
                bsel_r   <= 2'h0;
                tsum_r   <= 8'h00;
                reg_addr <= {ctl_r[7:4], adr_r};
              end
              else if (op == `ML_OP_BCAST || op == `ML_OP_WRITE)
              begin
                reg_wr    <= 1'b1;
                reg_addr  <= {ctl_r[7:4], adr_r};
                reg_wdata <= dat_r;
              end
            end
            else
            begin
              cnt_r <= cnt_r + 4'h1;
              sum_r <= sum_r + rsh_r;
              if (cnt_r == 4'h1) ctl_r <= rsh_r;
              if (cnt_r == 4'h2) adr_r <= rsh_r;
              if (cnt_r >= 4'h3) dat_r <= {rsh_r, dat_r[31:8]};
            end
          end
        end
        DV_RESP:
        begin
          if (tload)
          begin
            tsum_r <= tsum_r + tbyte;
            // Step the address with each fetch, so the next fetch sees the next word
            if (phase_r == 3'h2 || (phase_r == 3'h3 && bsel_r == 2'h3))
            begin
              word_r   <= reg_rdata;        // Fetch next word
              reg_addr <= reg_addr + 12'h001;
            end
            if (phase_r == 3'h2)
              phase_r <= 3'h3;
            else if (phase_r == 3'h3)
            begin
              bsel_r <= bsel_r + 2'h1;
              if (bsel_r == 2'h3)
              begin
                nword_r  <= nword_r - 8'h01;
                if (nword_r == 8'h01)
                  phase_r <= 3'h4;
              end
            end
            else if (phase_r == 3'h4)
              st_r <= DV_WAIT;
            else
              phase_r <= phase_r + 3'h1;
          end
        end
        DV_WAIT:
          st_r <= tbusy_r ? DV_WAIT : DV_RECV; // Last byte drains
        default:
          st_r <= DV_RECV;
      endcase
    end
  end

  // ----------------------------------------
  // Transmitter, LSB first
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      tbusy_r <= 1'b0;
      tsh_r   <= 10'h3FF;
      tdiv_r  <= 8'h00;
      tbit_r  <= 4'h0;
    end
    else if (tload)
    begin
      tbusy_r <= 1'b1;
      tsh_r   <= {1'b1, tbyte, 1'b0};
      tdiv_r  <= 8'h00;
      tbit_r  <= 4'h0;
    end
    else if (tbusy_r)
    begin
      tdiv_r <= (tdiv_r == `ML_BIT_DIV) ? 8'h00 : tdiv_r + 8'h01;
      if (tdiv_r == `ML_BIT_DIV)
      begin
        tsh_r  <= {1'b1, tsh_r[9:1]};
        tbit_r <= tbit_r + 4'h1;
        if (tbit_r == 4'h9)
          tbusy_r <= 1'b0;
      end
    end
  end

  assign link.tx_dev    = tbusy_r ? tsh_r[0] : 1'b1;
  assign link.tx_dev_oe = (st_r != DV_RECV);
endmodule

/* verilog/mlink_host.sv */
`include "mlink_defs.svh"
// ----------------------------------------
// Host end: sends commands, gathers reply
// ----------------------------------------
module mlink_host
  import mlink_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  mlink_if.host            link,
  input  wire logic        cmd_valid,   // Command request
  output logic             cmd_ready,   // High when idle and gap elapsed
  input  wire logic [1:0]  cmd_op,      // Read, write or broadcast
  input  wire logic [11:0] cmd_addr,
  input  wire logic [31:0] cmd_data,    // Write data; bits 7..0 word count on read
  output logic             rsp_valid,   // One-cycle pulse per received byte
  output logic [7:0]       rsp_byte
);
  logic [3:0]  idx_r;            // Byte index of command
  logic        busy_r;
  logic [63:0] frm_r;            // Seven bytes, LSB byte first
  logic [7:0]  sum_r;
  logic [9:0]  sh_r;
  logic [7:0]  div_r;
  logic [3:0]  bit_r;
  logic        bact_r;           // Byte in flight
  logic        was_bc_r;
  logic [15:0] gap_r;            // Broadcast spacing counter
  logic [7:0]  nbyte;

  assign cmd_ready = !busy_r && (gap_r == 16'h0000);
  assign nbyte = (idx_r == 4'h7) ? (~sum_r) + `ML_CHK_CONST
                                 : frm_r[7:0];

  // Command sequencer, eight bytes per frame
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      busy_r <= 1'b0;
      idx_r  <= 4'h0;
      frm_r  <= 64'h0;
      sum_r  <= 8'h00;
      sh_r   <= 10'h3FF;
      div_r  <= 8'h00;
      bit_r  <= 4'h0;
      bact_r <= 1'b0;
      gap_r  <= 16'h0000;
      was_bc_r <= 1'b0;
    end
    else
    begin
      if (gap_r != 16'h0000) gap_r <= gap_r - 16'h0001;
      if (cmd_valid && cmd_ready)
      begin
        busy_r   <= 1'b1;
        idx_r    <= 4'h0;
        sum_r    <= 8'h00;
        was_bc_r <= (cmd_op == `ML_OP_BCAST);
        frm_r    <= {8'h00, cmd_data, cmd_addr[7:0],
                     cmd_addr[11:8], 2'h0, cmd_op, `ML_HEAD_BYTE};
      end
      else if (busy_r && !bact_r)
      begin
        bact_r <= 1'b1;
        sh_r   <= {1'b1, nbyte, 1'b0};
        sum_r  <= sum_r + nbyte;
        frm_r  <= {8'h00, frm_r[63:8]};
        div_r  <= 8'h00;
        bit_r  <= 4'h0;
      end
      else if (bact_r)
      begin
        div_r <= (div_r == `ML_BIT_DIV) ? 8'h00 : div_r + 8'h01;
        if (div_r == `ML_BIT_DIV)
        begin
          sh_r  <= {1'b1, sh_r[9:1]};
          bit_r <= bit_r + 4'h1;
          if (bit_r == 4'h9)
          begin
            bact_r <= 1'b0;
            idx_r  <= idx_r + 4'h1;
            if (idx_r == 4'h7)
            begin
              busy_r <= 1'b0;
              if (was_bc_r) gap_r <= 16'(`ML_BCAST_GAP_CYC);
            end
          end
        end
      end
    end
  end

  assign link.tx_host = bact_r ? sh_r[0] : 1'b1;

  // ----------------------------------------
  // Reply receiver, two-flop synchronised
  // ----------------------------------------
  logic       s1_r;
  logic       s2_r;
  logic       rb_r;
  logic [7:0] rdiv_r;
  logic [3:0] rbit_r;
  logic [7:0] rsh_r;

  always_ff @(posedge clk_sys)
  begin
    s1_r <= reset_n ? (link.tx_dev | !link.tx_dev_oe) : 1'b1;
    s2_r <= reset_n ? s1_r : 1'b1;
  end

  // Mid-bit sampling of reply bytes
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rb_r <= 1'b0;
      rdiv_r <= 8'h00;
      rbit_r <= 4'h0;
      rsh_r <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_byte <= 8'h00;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (!rb_r)
      begin
        rdiv_r <= 8'h00;
        rbit_r <= 4'h0;
        rb_r <= !s2_r;
      end
      else
      begin
        rdiv_r <= (rdiv_r == `ML_BIT_DIV) ? 8'h00 : rdiv_r + 8'h01;
        if (rdiv_r == (`ML_BIT_DIV >> 1) && rbit_r >= 4'h1 && rbit_r <= 4'h8)
          rsh_r <= {s2_r, rsh_r[7:1]};
        if (rdiv_r == `ML_BIT_DIV)
        begin
          rbit_r <= rbit_r + 4'h1;
          if (rbit_r == 4'h9)
          begin
            rb_r <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_byte <= rsh_r;
          end
        end
      end
    end
  end
endmodule

/* dv/mlink_link_asserts.sv */
`include "mlink_defs.svh"
// ----------
// Wire checks
// ----------
module mlink_link_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic tx_host,
  input wire logic tx_dev,
  input wire logic tx_dev_oe
);
  logic [7:0] ph_r;    // Host line bit position
  logic [7:0] pd_r;    // Device line bit position
  logic [7:0] sh_r;    // Device byte, LSB first
  logic       first_r; // First byte of a reply
  wire  [7:0] off  = pd_r - 8'h25;
  wire        samp = (pd_r >= 8'h25) && (pd_r <= 8'hD4) && (off % 8'h19 == 8'h00);

  // Position 0 is the first low cycle
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n) ph_r <= 8'h00;
    else if (ph_r != 8'h00 || !tx_host) ph_r <= (ph_r == 8'hF9) ? 8'h00 : ph_r + 8'h01;
  end

  // Same count on the reply line
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n) pd_r <= 8'h00;
    else if (pd_r != 8'h00 || !tx_dev) pd_r <= (pd_r == 8'hF9) ? 8'h00 : pd_r + 8'h01;
  end

  // Mid-bit sampling, newest bit on top
  always_ff @(posedge clk_sys)
  begin
    if (samp) sh_r <= {tx_dev, sh_r[7:1]};
  end

  // Marks the opening byte of a reply
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n) first_r <= 1'b0;
    else if ($rose(tx_dev_oe)) first_r <= 1'b1;
    else if (pd_r == 8'hED) first_r <= 1'b0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_host_stop; ph_r == 8'hED |-> tx_host; endproperty
  a_host_stop: assert property (p_host_stop) else $error("host stop bit low");
  property p_dev_stop; pd_r == 8'hED |-> tx_dev; endproperty
  a_dev_stop: assert property (p_dev_stop) else $error("reply stop bit low");
  property p_host_start; ph_r == 8'h0C |-> !tx_host; endproperty
  a_host_start: assert property (p_host_start) else $error("host start bit short");
  property p_dev_start; pd_r == 8'h0C |-> !tx_dev; endproperty
  a_dev_start: assert property (p_dev_start) else $error("reply start bit short");
  property p_host_bit; $fell(tx_host) |-> ##24 !tx_host; endproperty
  a_host_bit: assert property (p_host_bit) else $error("host low bit short");
  property p_dev_bit; $fell(tx_dev) |-> ##24 !tx_dev; endproperty
  a_dev_bit: assert property (p_dev_bit) else $error("reply low bit short");
  property p_head; first_r && pd_r == 8'hED |-> sh_r == `ML_HEAD_BYTE; endproperty
  a_head: assert property (p_head) else $error("reply header wrong");
  property p_idle; !tx_dev_oe |-> tx_dev; endproperty
  a_idle: assert property (p_idle) else $error("released line not high");
  property p_oe_hold; pd_r != 8'h00 && pd_r < 8'hED |-> tx_dev_oe; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("line dropped mid byte");
endmodule

/* dv/metering_link_read_broadcast_frames_tb.sv */
`include "mlink_defs.svh"
module metering_link_read_broadcast_frames_tb
  import mlink_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Stimulus and observed signals
  // ----------
  logic        clk_sys = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, bad_line = 1'b1;
  logic        cmd_ready, rsp_valid, reg_wr, frame_bad, reg_wr2, frame_bad2;
  logic [1:0]  cmd_op = 2'h0;
  logic [11:0] cmd_addr = 12'h000, reg_addr, reg_addr2;
  logic [31:0] cmd_data = 32'h00000000, reg_wdata, reg_wdata2, reg_rdata;
  logic [7:0]  rsp_byte;
  logic [7:0]  rq[$]; // Reply bytes in order
  int          error_cnt, num_checks, cyc, t_take, t1, wr_cnt, bad_cnt, wr2_cnt, bad2_cnt;
  int          oe_cyc, oe2_cyc; // Cycles each device drove its line

  // Register file model, seen through reg_addr
  function automatic logic [31:0] word_of(input logic [11:0] a);
    return {8'hC3, a, a ^ 12'h5A5};
  endfunction

  mlink_if u_mlink_if ();
  mlink_if u_mlink_if_bad (); // Second device fed by hand-made frames
  assign u_mlink_if_bad.tx_host = bad_line;
  assign reg_rdata = word_of(reg_addr);
  mlink_host u_mlink_host (.clk_sys(clk_sys), .reset_n(reset_n), .link(u_mlink_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
  mlink_dev u_mlink_dev (.clk_sys(clk_sys), .reset_n(reset_n), .link(u_mlink_if),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .frame_bad(frame_bad));
  mlink_dev u_mlink_dev_bad (.clk_sys(clk_sys), .reset_n(reset_n), .link(u_mlink_if_bad),
    .reg_wr(reg_wr2), .reg_addr(reg_addr2), .reg_wdata(reg_wdata2),
    .reg_rdata(32'h00000000), .frame_bad(frame_bad2));
  mlink_link_asserts u_mlink_link_asserts (.clk_sys(clk_sys), .reset_n(reset_n),
    .tx_host(u_mlink_if.tx_host), .tx_dev(u_mlink_if.tx_dev),
    .tx_dev_oe(u_mlink_if.tx_dev_oe));

  always #20 clk_sys = ~clk_sys;

  // Event counters, sampled at the clock edge
  always @(posedge clk_sys)
  begin
    cyc++;
    if (rsp_valid === 1'b1) rq.push_back(rsp_byte);
    if (reg_wr === 1'b1) wr_cnt++;
    if (frame_bad === 1'b1) bad_cnt++;
    if (reg_wr2 === 1'b1) wr2_cnt++;
    if (frame_bad2 === 1'b1) bad2_cnt++;
    if (u_mlink_if.tx_dev_oe === 1'b1) oe_cyc++;
    if (u_mlink_if_bad.tx_dev_oe === 1'b1) oe2_cyc++;
  end

  // ----------
  // Compare and drive tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) error_cnt++;
    if (got !== exp) $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
  endtask

  // Holds the request until an edge sees ready
  task automatic send(input logic [1:0] op, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_addr  <= a;
    cmd_data  <= d;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1 && i < 30000)
    begin
      @(posedge clk_sys);
      i++;
    end
    t_take = cyc;
    cmd_valid <= 1'b0;
    chk(int'(i < 30000), 1);
  endtask

  // Single-device write lands with the same frame layout
  task automatic t_write(input logic [11:0] a, input logic [31:0] d);
    int c;
    c = wr_cnt;
    send(`ML_OP_WRITE, a, d);
    for (int i = 0; i < 2500 && wr_cnt == c; i++) @(posedge clk_sys);
    repeat (300) @(posedge clk_sys);
    chk(wr_cnt, c + 1);
    chk(reg_addr, a);
    chk(reg_wdata, d);
  endtask

  // Reads the first host byte straight off the wire
  task automatic grab(output logic [7:0] b);
    for (int i = 0; i < 100 && u_mlink_if.tx_host !== 1'b0; i++) @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
    for (int j = 0; j < 8; j++)
    begin
      repeat (25) @(posedge clk_sys);
      b[j] = u_mlink_if.tx_host;
    end
  endtask

  task automatic t_read(input logic [11:0] a, input logic [7:0] nreq);
    int n;
    logic [7:0] b, sum;
    logic [31:0] w;
    n = (nreq == 8'h00) ? 1 : int'(nreq);
    rq.delete();
    send(`ML_OP_READ, a, {24'h000000, nreq});
    grab(b);
    chk(b, `ML_HEAD_BYTE);
    for (int i = 0; i < 300 * (4 * n + 12) && rq.size() < 4 * n + 4; i++) @(posedge clk_sys);
    repeat (300) @(posedge clk_sys);
    chk(rq.size(), 4 * n + 4);
    chk(rq[0], `ML_HEAD_BYTE);
    chk(rq[1], {a[11:8], 4'h1});
    chk(rq[2], n[7:0]);
    sum = `ML_HEAD_BYTE + {a[11:8], 4'h1} + n[7:0];
    for (int k = 0; k < n; k++)
    begin
      w = word_of(a + k[11:0]);
      for (int j = 0; j < 4; j++)
      begin
        chk(rq[3 + 4 * k + j], w[8 * j +: 8]);
        sum = sum + w[8 * j +: 8];
      end
    end
    chk(rq[4 * n + 3], 8'(~sum + `ML_CHK_CONST));
  endtask

  task automatic t_bcast(input logic [11:0] a, input logic [31:0] d);
    int c, o;
    c = wr_cnt;
    o = oe_cyc;
    rq.delete();
    send(`ML_OP_BCAST, a, d);
    for (int i = 0; i < 2500 && wr_cnt == c; i++) @(posedge clk_sys);
    repeat (300) @(posedge clk_sys);
    chk(wr_cnt, c + 1);
    chk(reg_addr, a);
    chk(reg_wdata, d);
    chk(oe_cyc, o);
    chk(rq.size(), 0);
  endtask

  // Hand-built broadcast, check byte spoiled when good is low
  task automatic t_bad(input logic good);
    logic [7:0] f[8];
    logic [7:0] sum;
    logic [9:0] bits;
    int c, b;
    f = '{`ML_HEAD_BYTE, 8'h6C, 8'h3B, 8'hEF, 8'hBE, 8'hAD, 8'hDE, 8'h00};
    sum = 8'h00;
    for (int k = 0; k < 7; k++) sum = sum + f[k];
    f[7] = (~sum + `ML_CHK_CONST) ^ {7'h00, !good};
    c = wr2_cnt;
    b = bad2_cnt;
    for (int k = 0; k < 80; k++)
    begin
      bits = {1'b1, f[k / 10], 1'b0};
      @(posedge clk_sys);
      bad_line <= bits[k % 10];
      repeat (24) @(posedge clk_sys);
    end
    repeat (300) @(posedge clk_sys);
    chk(wr2_cnt, c + int'(good));
    chk(bad2_cnt, b + int'(!good));
    chk(oe2_cyc, 0);
    if (good) chk(reg_addr2, 12'h63B);
    if (good) chk(reg_wdata2, 32'hDEADBEEF);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------
  // Main sequence
  // ----------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_read(12'h3A4, 8'h00);
    t_read(12'h1FE, 8'h03);
    t_write(12'h0A7, 32'h7E5D3C1B);
    t_bcast(12'h5C1, 32'h89ABCDEF);
    t1 = t_take;
    t_bcast(12'h5C2, 32'h01234567);
    // Gap counts from the end of the eight-byte frame, 250 cycles a byte
    chk(int'((t_take - t1) >= `ML_BCAST_GAP_CYC + 2000), 1);
    t_bad(1'b0);
    t_bad(1'b1);
    chk(bad_cnt, 0);
    close_out;
  end

  // Run is near 50k cycles; cut off at 80k
  initial
  begin
    #3200000;
    error_cnt++;
    close_out;
  end
endmodule
